/* File: logic/pec_top.sv */
// module: per-pin edge change detector with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module pec_top #(
  parameter int NPINS = 8 // pins watched, at most 32
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [NPINS-1:0] pin_in,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  irq,
  output logic                  wake
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [NPINS-1:0] sync1;     // first synchroniser stage
    logic [NPINS-1:0] sync2;     // second synchroniser stage
    logic [NPINS-1:0] prev;      // previous synchronised sample
    logic [NPINS-1:0] rise_en;   // rise_edge_enable_bits
    logic [NPINS-1:0] fall_en;   // fall_edge_enable_bits
    logic [NPINS-1:0] flags;     // per_pin_change_flags
    logic             master_en; // change_int_master_enable
    logic             sleep;     // sleep state
    logic [pec_pkg::EVT_W-1:0] evt_stat; // sticky event status
    logic [pec_pkg::EVT_W-1:0] evt_mask; // event mask
    logic             aw_got;    // write address held
    logic [7:0]       aw_addr;
    logic             w_got;     // write data held
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             irq;
    logic             wake;
  } pec_state_s;

  pec_state_s st_reg;  // registered state
  pec_state_s st_next; // next state
  logic rst_s1_reg;    // reset release stage one
  logic rst_n_reg;     // synchronised reset

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // merge write data into a field under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // widen pin vector to a bus word, upper bits read as zero
  function automatic logic [31:0] to_word(input logic [NPINS-1:0] v);
    logic [31:0] r;
    r = pec_pkg::RESET_WORD;
    r[NPINS-1:0] = v;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state logic
  logic [NPINS-1:0] rise_hit;   // enabled rising edges this cycle
  logic [NPINS-1:0] fall_hit;   // enabled falling edges this cycle
  logic [NPINS-1:0] edge_hit;   // any enabled edge
  logic             do_write;   // write address and data both held
  logic [31:0]      wmerged;    // flag word after strobes
  logic [NPINS-1:0] flags_after;
  logic [pec_pkg::EVT_W-1:0] evt_set;

  always_comb begin
    st_next = st_reg;
    // synchroniser and sample history
    st_next.sync1 = pin_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    // per-pin detectors, each gated by its own enable
    rise_hit = st_reg.sync2 & ~st_reg.prev & st_reg.rise_en;
    fall_hit = ~st_reg.sync2 & st_reg.prev & st_reg.fall_en;
    edge_hit = rise_hit | fall_hit;
    flags_after = st_reg.flags;
    evt_set = '0;
    do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    wmerged = strb_merge(to_word(st_reg.flags), st_reg.w_data, st_reg.w_strb);

    // write channel acceptance, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // register writes, if and else-if address decode
    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = pec_pkg::RESP_OKAY;
      if (st_reg.aw_addr == pec_pkg::ADDR_RISE_EN) begin
        st_next.rise_en = NPINS'(strb_merge(to_word(st_reg.rise_en), st_reg.w_data, st_reg.w_strb));
      end else if (st_reg.aw_addr == pec_pkg::ADDR_FALL_EN) begin
        st_next.fall_en = NPINS'(strb_merge(to_word(st_reg.fall_en), st_reg.w_data, st_reg.w_strb));
      end else if (st_reg.aw_addr == pec_pkg::ADDR_FLAGS) begin
        // zero clears, one leaves the flag as it stands
        flags_after = st_reg.flags & NPINS'(wmerged);
      end else if (st_reg.aw_addr == pec_pkg::ADDR_INT_CTRL) begin
        if (st_reg.w_strb[0]) begin
          st_next.master_en = st_reg.w_data[pec_pkg::CTRL_MASTER_EN_BIT];
          st_next.sleep     = st_reg.w_data[pec_pkg::CTRL_SLEEP_BIT];
        end
      end else if (st_reg.aw_addr == pec_pkg::ADDR_PIN_STATE) begin
        st_next.bresp = pec_pkg::RESP_OKAY; // read only, write ignored
      end else if (st_reg.aw_addr == pec_pkg::ADDR_IRQ_STAT) begin
        if (st_reg.w_strb[0]) begin
          st_next.evt_stat = st_reg.evt_stat & ~st_reg.w_data[pec_pkg::EVT_W-1:0];
        end
      end else if (st_reg.aw_addr == pec_pkg::ADDR_IRQ_MASK) begin
        if (st_reg.w_strb[0]) begin
          st_next.evt_mask = st_reg.w_data[pec_pkg::EVT_W-1:0];
        end
      end else begin
        st_next.bresp = pec_pkg::RESP_SLVERR; // unmapped address
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // a new edge beats a coinciding clear, flags set even with master off
    st_next.flags = flags_after | edge_hit;

    // sticky events, set wins over a write-one clear
    evt_set[pec_pkg::EVT_CHANGE_BIT] = |edge_hit;
    if (st_reg.sleep && st_reg.master_en && (|edge_hit)) begin
      // flag is written in this same edge, and wake is registered at this same edge too
      st_next.sleep = 1'b0;
      evt_set[pec_pkg::EVT_WAKE_BIT] = 1'b1;
    end
    st_next.evt_stat = st_next.evt_stat | evt_set;
    st_next.wake = st_reg.sleep && !st_next.sleep;

    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = pec_pkg::RESP_OKAY;
      if (s_axi_araddr == pec_pkg::ADDR_RISE_EN) begin
        st_next.rdata = to_word(st_reg.rise_en);
      end else if (s_axi_araddr == pec_pkg::ADDR_FALL_EN) begin
        st_next.rdata = to_word(st_reg.fall_en);
      end else if (s_axi_araddr == pec_pkg::ADDR_FLAGS) begin
        st_next.rdata = to_word(st_reg.flags);
      end else if (s_axi_araddr == pec_pkg::ADDR_INT_CTRL) begin
        st_next.rdata = pec_pkg::RESET_WORD;
        st_next.rdata[pec_pkg::CTRL_MASTER_EN_BIT] = st_reg.master_en;
        st_next.rdata[pec_pkg::CTRL_SUMMARY_BIT]   = |st_reg.flags;
        st_next.rdata[pec_pkg::CTRL_SLEEP_BIT]     = st_reg.sleep;
      end else if (s_axi_araddr == pec_pkg::ADDR_PIN_STATE) begin
        st_next.rdata = to_word(st_reg.sync2);
      end else if (s_axi_araddr == pec_pkg::ADDR_IRQ_STAT) begin
        st_next.rdata = pec_pkg::RESET_WORD;
        st_next.rdata[pec_pkg::EVT_W-1:0] = st_reg.evt_stat;
      end else if (s_axi_araddr == pec_pkg::ADDR_IRQ_MASK) begin
        st_next.rdata = pec_pkg::RESET_WORD;
        st_next.rdata[pec_pkg::EVT_W-1:0] = st_reg.evt_mask;
      end else begin
        st_next.rdata = pec_pkg::RESET_WORD;
        st_next.rresp = pec_pkg::RESP_SLVERR; // unmapped address
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // interrupt request: change event needs the master enable too
    st_next.irq = (|(st_next.evt_stat & st_next.evt_mask & {1'b1, st_next.master_en}))
                  && (st_next.master_en || !(st_next.evt_stat[pec_pkg::EVT_CHANGE_BIT]
                  && st_next.evt_mask[pec_pkg::EVT_CHANGE_BIT]) || st_next.evt_stat[pec_pkg::EVT_WAKE_BIT]
                  && st_next.evt_mask[pec_pkg::EVT_WAKE_BIT]);
  end

  // ready while nothing of that channel is held
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready  = !st_reg.w_got;
  assign s_axi_arready = !st_reg.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;
  assign irq          = st_reg.irq;
  assign wake         = st_reg.wake;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_rise_seen(int i);
    st_reg.sync2[i] && !st_reg.prev[i] && st_reg.rise_en[i];
  endsequence

  chk_rise_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    s_rise_seen(0) |=> st_reg.flags[0]) else $error("rising edge did not set flag");
  chk_fall_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (!st_reg.sync2[0] && st_reg.prev[0] && st_reg.fall_en[0]) |=> st_reg.flags[0])
    else $error("falling edge did not set flag");
  chk_no_enable_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (!st_reg.flags[0] && !st_reg.rise_en[0] && !st_reg.fall_en[0] && !do_write) |=> !st_reg.flags[0])
    else $error("flag set without enable");
  chk_clear_keeps_edge: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (do_write && st_reg.aw_addr == pec_pkg::ADDR_FLAGS && edge_hit[0]) |=> st_reg.flags[0])
    else $error("edge lost during clear");
  chk_zero_clears: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (do_write && st_reg.aw_addr == pec_pkg::ADDR_FLAGS && st_reg.w_strb[0] && !st_reg.w_data[0]
     && !edge_hit[0]) |=> !st_reg.flags[0]) else $error("flag not cleared by zero");
  chk_no_irq_master: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (!st_reg.master_en && !st_reg.evt_stat[pec_pkg::EVT_WAKE_BIT] && !st_next.master_en) |=> !irq)
    else $error("irq while master enable clear");
  chk_summary_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == pec_pkg::ADDR_INT_CTRL)
    |=> s_axi_rdata[pec_pkg::CTRL_SUMMARY_BIT] == |$past(st_reg.flags))
    else $error("summary flag mismatch");
  chk_wake_after_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    $rose(wake) |-> (|st_reg.flags) && !st_reg.sleep) else $error("wake before flag");
  chk_sync_two_stage: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    ##2 st_reg.sync2 == $past(pin_in, 2)) else $error("sync depth wrong");
endmodule
`default_nettype wire

/* File: shared/pec_pkg.sv */
// package: register map, widths and reset values of the pin edge change block
package pec_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] ADDR_RISE_EN   = 8'h00; // rise_edge_enable_bits
  localparam logic [7:0] ADDR_FALL_EN   = 8'h04; // fall_edge_enable_bits
  localparam logic [7:0] ADDR_FLAGS     = 8'h08; // per_pin_change_flags, write zero clears
  localparam logic [7:0] ADDR_INT_CTRL  = 8'h0C; // interrupt_control_reg
  localparam logic [7:0] ADDR_PIN_STATE = 8'h10; // synchronised pin levels, read only
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14; // sticky event status, write one clears
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18; // event mask
  // interrupt_control_reg fields
  localparam int CTRL_MASTER_EN_BIT  = 0; // change_int_master_enable
  localparam int CTRL_SUMMARY_BIT    = 1; // change_int_summary_flag, read only
  localparam int CTRL_SLEEP_BIT      = 2; // sleep state, software sets, wake clears
  // event status fields
  localparam int EVT_CHANGE_BIT      = 0; // any enabled edge seen
  localparam int EVT_WAKE_BIT        = 1; // a wake from sleep happened
  localparam int EVT_W               = 2;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

/* File: tb/pec_pin_model.sv */
// pin side model: drives the port pin levels seen by the edge detector
`timescale 1ns/1ps
`default_nettype none
module pec_pin_model #(
  parameter int NPINS = 8 // pins driven
) (
  input  wire logic             clk_sys,
  output var  logic [NPINS-1:0] pin_in
);
  // pins idle low until the bench moves them
  initial begin
    pin_in = '0;
  end

  // change all pin levels at once, right after a rising edge
  task automatic set_pins(input logic [NPINS-1:0] lvl);
    @(posedge clk_sys);
    pin_in <= lvl;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_pin_edge_change_interrupt.sv */
// testbench: register access, edge detection, interrupt and sleep wake of the edge change block
`timescale 1ns/1ps
`default_nettype none
module tb_pin_edge_change_interrupt;
  logic        clk_sys;       // system clock
  logic        nrst;          // active low reset
  logic [7:0]  pin_in;        // pin levels from the model
  logic [7:0]  awaddr;        // write address
  logic        awvalid;       // write address valid
  logic        awready;       // write address ready
  logic [31:0] wdata;         // write data
  logic [3:0]  wstrb;         // write byte strobes
  logic [1:0]  bs;            // last write response
  logic        wvalid;        // write data valid
  logic        wready;        // write data ready
  logic [1:0]  bresp;         // write response
  logic        bvalid;        // write response valid
  logic        bready;        // write response ready
  logic [7:0]  araddr;        // read address
  logic        arvalid;       // read address valid
  logic        arready;       // read address ready
  logic [31:0] rdata;         // read data
  logic [1:0]  rresp;         // read response
  logic        rvalid;        // read data valid
  logic        rready;        // read data ready
  logic        irq;           // interrupt output
  logic        wake;          // wake pulse
  int          miscompares;   // mismatches seen
  int          total_checks;  // comparisons made
  logic [31:0] rd;            // last read word
  logic [1:0]  rs;            // last read response
  logic        seen;          // wake pulse observed

  pec_top #(.NPINS(8)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .pin_in(pin_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .wake(wake)
  );
  pec_pin_model #(.NPINS(8)) PINS (.clk_sys(clk_sys), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // clock and time zero values
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    wstrb = 4'hF;
    {araddr, arvalid, rready} = '0;
    nrst = 1'b0;
    miscompares = 0;
    total_checks = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict, the only place the run ends
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // compare one word against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // write one word, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    forever begin
      @(posedge clk_sys);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bs = bresp;
        bready <= 1'b0;
        // one edge passes so a following call never reassigns bready in this step
        @(posedge clk_sys);
        return;
      end
    end
  endtask

  // read one word and its response
  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arvalid && arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        // one edge passes so a following call never reassigns rready in this step
        @(posedge clk_sys);
        return;
      end
    end
  endtask

  // read a register and compare its word
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200us;
    miscompares++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    wait_cyc(2);
    nrst <= 1'b1;
    wait_cyc(4);
    rchk(pec_pkg::ADDR_FLAGS, pec_pkg::RESET_WORD);
    rchk(pec_pkg::ADDR_INT_CTRL, pec_pkg::RESET_WORD);
    axi_read(8'h1C);
    chk({30'h0, rs}, {30'h0, pec_pkg::RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    // write responses: unmapped address refused, read-only register ignores the write
    axi_write(8'h1C, 32'h0000_0000);
    chk({30'h0, bs}, {30'h0, pec_pkg::RESP_SLVERR});
    axi_write(pec_pkg::ADDR_PIN_STATE, 32'h0000_00FF);
    chk({30'h0, bs}, {30'h0, pec_pkg::RESP_OKAY});
    rchk(pec_pkg::ADDR_PIN_STATE, 32'h0000_0000);
    // pin0 rise only, pin1 fall only, pin2 both, pin3 none
    axi_write(pec_pkg::ADDR_RISE_EN, 32'h0000_0005);
    axi_write(pec_pkg::ADDR_FALL_EN, 32'h0000_0006);
    PINS.set_pins(8'h0F);
    wait_cyc(8);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0005);
    rchk(pec_pkg::ADDR_INT_CTRL, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_write(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    rchk(pec_pkg::ADDR_INT_CTRL, 32'h0000_0000);
    PINS.set_pins(8'h00);
    wait_cyc(8);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0006);
    rchk(pec_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    // interrupt: master enable, mask, clear
    axi_write(pec_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_write(pec_pkg::ADDR_INT_CTRL, 32'h0000_0001);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_write(pec_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_write(pec_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    axi_write(pec_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(pec_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // clear only the bit already seen, by and with its inverse
    axi_read(pec_pkg::ADDR_FLAGS);
    axi_write(pec_pkg::ADDR_FLAGS, ~(rd & 32'h0000_0002));
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0004);
    axi_write(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    // edge lands in the same cycle as a clearing write
    PINS.set_pins(8'h01);
    // handshake lands so the write is applied at the edge the detector fires
    wait_cyc(1);
    axi_write(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0001);
    rchk(pec_pkg::ADDR_PIN_STATE, 32'h0000_0001);
    // a zero written with no byte strobes clears nothing
    wstrb <= 4'h0;
    axi_write(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    wstrb <= 4'hF;
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0001);
    // sleep, a disabled edge does not wake, an enabled one does
    axi_write(pec_pkg::ADDR_FLAGS, 32'h0000_0000);
    axi_write(pec_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    axi_write(pec_pkg::ADDR_INT_CTRL, 32'h0000_0005);
    PINS.set_pins(8'h00);
    wait_cyc(8);
    rchk(pec_pkg::ADDR_INT_CTRL, 32'h0000_0005);
    seen = 1'b0;
    PINS.set_pins(8'h01);
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clk_sys);
      seen = (wake === 1'b1);
    end
    chk({31'h0, seen}, 32'h0000_0001);
    rchk(pec_pkg::ADDR_FLAGS, 32'h0000_0001);
    rchk(pec_pkg::ADDR_INT_CTRL, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(pec_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    end_sim();
  end
endmodule
`default_nettype wire
